// ---- fpd_regs.svh ----
// Register map, field positions and timing figures of the front-panel port.
// Assumes a 250 MHz clock and a byte-addressed Avalon-MM slave port.
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH

`define FPD_ADDR_W 8
`define FPD_ADDR_FREQ_SHIFT 8'h00
`define FPD_ADDR_BAR_SHIFT 8'h04
`define FPD_ADDR_LOAD 8'h08
`define FPD_ADDR_MTX_INSTR 8'h0C
`define FPD_ADDR_MTX_CHAR 8'h10
`define FPD_ADDR_LEGEND 8'h14
`define FPD_ADDR_VIEW 8'h18
`define FPD_ADDR_LAMP 8'h1C
`define FPD_ADDR_TUNE 8'h20
`define FPD_ADDR_KEYS 8'h24
`define FPD_ADDR_IDENT 8'h28
`define FPD_ADDR_STATUS 8'h2C
`define FPD_ADDR_CTRL 8'h30

// Strobe select bits; the two load bits are also the bit positions of the load register
`define FPD_STB_FREQ_LOAD 0
`define FPD_STB_BAR_LOAD 1
`define FPD_STB_FREQ_SHIFT 2
`define FPD_STB_BAR_SHIFT 3
`define FPD_STB_MTX 4
`define FPD_STB_N 5

`define FPD_FREQ_BITS 6
`define FPD_BAR_BITS 2
`define FPD_IMAGE_BYTES 5'h14
`define FPD_LEGEND_BITS 7
`define FPD_BIT_BUILT_IN_TEST 7
`define FPD_LAMP_BITS 3
`define FPD_VIEW_RESET 8'h80
`define FPD_LAMP_RESET 3'h7
`define FPD_KEY_ROWS 6
`define FPD_KEY_COLS 8
`define FPD_KEY_SCAN_BIT 3
`define FPD_CTRL_MUTE 0
`define FPD_CTRL_CMP_EN 1
`define FPD_ST_FREQ_CNT 0
`define FPD_ST_BAR_CNT 8
`define FPD_ST_FREQ_SHORT 16
`define FPD_ST_BAR_SHORT 17
`define FPD_ST_KEY_DOWN 18

// Timing in its own unit and derived cycle counts (least times round up)
`define FPD_CLK_MHZ 250
`define FPD_SETUP_NS 40
`define FPD_STROBE_NS 120
`define FPD_HOLD_NS 40
`define FPD_FREEZE_NS 20
`define FPD_NS2CYC(ns) (((ns) * `FPD_CLK_MHZ + 999) / 1000)
`define FPD_LCD_DRIVE_HZ 100
`define FPD_LCD_HALF_CYC (`FPD_CLK_MHZ * 1000000 / (2 * `FPD_LCD_DRIVE_HZ))
`define FPD_PWM_STEP_CYC 64

`endif

// ---- fpd_pkg.sv ----
// Types shared by the front-panel port files.
// Assumes fpd_regs.svh holds all numbers.
package fpd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_FREEZE,
		ST_ACK
	} fpd_state_e;
	typedef logic [7:0] fpd_tmr_t;
endpackage : fpd_pkg

// ---- fpd_lamp_drive.sv ----
// Low-frequency display drive square wave and backlight lamp PWM.
// Assumes level comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_lamp_drive #(
	parameter int LCD_HALF_CYC = `FPD_LCD_HALF_CYC,
	parameter int PWM_STEP_CYC = `FPD_PWM_STEP_CYC
) (
	input wire logic clock, // 250 MHz clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [`FPD_LAMP_BITS-1:0] level, // Brightness 0..7
	output logic lcd_drive, // Square wave to all modules
	output logic lamp_pwm // Lamp drive
);
	localparam int LEVELS = 1 << `FPD_LAMP_BITS;
	localparam int PERIOD = LEVELS * PWM_STEP_CYC;

	if (LCD_HALF_CYC < 1 || PWM_STEP_CYC < 1) begin : g_chk
		$error("fpd_lamp_drive: counts must be at least one");
	end

	logic [31:0] lcd_cnt_r;
	logic [31:0] pwm_cnt_r;

	// Free-running square wave the module drivers need to run
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lcd_cnt_r <= 32'h0000_0000;
			lcd_drive <= 1'b0;
		end else if (lcd_cnt_r == 32'(LCD_HALF_CYC - 1)) begin
			lcd_cnt_r <= 32'h0000_0000;
			lcd_drive <= !lcd_drive;
		end else begin
			lcd_cnt_r <= lcd_cnt_r + 32'h0000_0001;
		end
	end

	// Duty is (level+1) eighths, so level 7 is full on
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pwm_cnt_r <= 32'h0000_0000;
			lamp_pwm <= 1'b0;
		end else begin
			pwm_cnt_r <= (pwm_cnt_r == 32'(PERIOD - 1)) ? 32'h0000_0000 : pwm_cnt_r + 32'h0000_0001;
			lamp_pwm <= pwm_cnt_r < (32'(level) + 32'h0000_0001) * 32'(PWM_STEP_CYC);
		end
	end
endmodule : fpd_lamp_drive
`default_nettype wire

// ---- fpd_panel_port.sv ----
// Front-panel bus port: display strobes, legend latch, view angle, lamp level,
// tuning counter, key matrix and identification code behind Avalon-MM.
// Assumes encoder and key return pins are asynchronous; all else is on clock.
//
// Behaviour
// - Display image is twenty bytes per update
// - Bar byte shifts on low-going bar strobe
// - Frequency byte shifts on frequency strobe
// - Own load strobe moves shift register to display
// - Instruction byte loads with select held low
// - Character byte: select high, then matrix strobe
// - Matrix shows two rows of twenty characters
// - Legends driven from separate latch
// - View angle from written data value
// - Eight lamp levels through PWM
// - Continuous square wave drive to modules
// - Decoder writes displays and test/legend latch
// - Reads return counter, keys or identification
// - Counter halted briefly before it is read
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_panel_port #(
	parameter int LCD_HALF_CYC = `FPD_LCD_HALF_CYC,
	parameter logic [7:0] IDENT_CODE = 8'h5A, // Arbitrary value
	parameter int SETUP_CYC = `FPD_NS2CYC(`FPD_SETUP_NS),
	parameter int STROBE_CYC = `FPD_NS2CYC(`FPD_STROBE_NS),
	parameter int HOLD_CYC = `FPD_NS2CYC(`FPD_HOLD_NS),
	parameter int FREEZE_CYC = `FPD_NS2CYC(`FPD_FREEZE_NS)
) (
	input wire logic clock, // 250 MHz clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [`FPD_ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall, high until answer
	output logic [7:0] disp_data, // Data bus to display modules
	output logic freq_shift_n, // Frequency shift strobe
	output logic freq_load_n, // Frequency latch strobe
	output logic bar_shift_n, // Bar graph shift strobe
	output logic bar_load_n, // Bar graph latch strobe
	output logic matrix_char_strobe_n, // Dot matrix strobe
	output logic matrix_instr_data_select, // Low instruction, high data
	output logic [`FPD_LEGEND_BITS-1:0] legend, // Legend latch outputs
	output logic built_in_test, // Test control bit of latch
	output logic [7:0] view_angle, // Word to view angle converter
	output logic lamp_pwm, // Backlight lamp drive
	output logic lcd_drive, // Module drive square wave
	output logic speaker_mute, // Loudspeaker mute
	output logic comparator_en, // Gain comparator power
	output logic [`FPD_KEY_ROWS-1:0] key_row_n, // Key matrix row drive
	input wire logic [`FPD_KEY_COLS-1:0] key_return_n, // Key return lines
	input wire logic enc_a, // Shaft encoder phase A
	input wire logic enc_b // Shaft encoder phase B
);
	if (SETUP_CYC < 1 || STROBE_CYC < 1 || HOLD_CYC < 1 || FREEZE_CYC < 1 ||
			SETUP_CYC > 256 || STROBE_CYC > 256 || HOLD_CYC > 256 || FREEZE_CYC > 256) begin : g_chk
		$error("fpd_panel_port: strobe timing counts out of range");
	end

	function automatic logic [4:0] sat_inc(input logic [4:0] v);
		sat_inc = (v == 5'h1F) ? v : v + 5'h01;
	endfunction : sat_inc

	function automatic logic [7:0] tmr_load(input int cyc);
		tmr_load = 8'(cyc - 1);
	endfunction : tmr_load

	fpd_pkg::fpd_state_e state_r, state_nxt;
	fpd_pkg::fpd_tmr_t tmr_r, tmr_nxt;
	logic [`FPD_STB_N-1:0] stb_sel_r, stb_sel_nxt;
	logic wr_take, rd_take, strobe_wr, lane0;
	logic [31:0] rd_mux;
	logic [2:0] lamp_level_r;
	logic [4:0] freq_cnt_r, bar_cnt_r;
	logic freq_short_r, bar_short_r;
	logic [3:0] key_sel_r;
	logic [7:0] tune_count_r;
	logic a_s1_r, a_s2_r, a_d_r, b_s1_r, b_s2_r, b_d_r;
	logic [`FPD_KEY_COLS-1:0] key_s1_r, key_s2_r;

	assign wr_take = state_r == fpd_pkg::ST_IDLE && avs_write;
	assign rd_take = state_r == fpd_pkg::ST_IDLE && avs_read;
	assign lane0 = avs_byteenable[0];

	// Decode of writes that need a timed strobe cycle
	always_comb begin
		stb_sel_nxt = '0;
		if (lane0) begin
			unique case (avs_address)
				`FPD_ADDR_FREQ_SHIFT: stb_sel_nxt[`FPD_STB_FREQ_SHIFT] = 1'b1;
				`FPD_ADDR_BAR_SHIFT: stb_sel_nxt[`FPD_STB_BAR_SHIFT] = 1'b1;
				`FPD_ADDR_LOAD: begin
					stb_sel_nxt[`FPD_STB_FREQ_LOAD] = avs_writedata[`FPD_STB_FREQ_LOAD];
					stb_sel_nxt[`FPD_STB_BAR_LOAD] = avs_writedata[`FPD_STB_BAR_LOAD];
				end
				`FPD_ADDR_MTX_INSTR, `FPD_ADDR_MTX_CHAR: stb_sel_nxt[`FPD_STB_MTX] = 1'b1;
				default: stb_sel_nxt = '0;
			endcase
		end
		strobe_wr = |stb_sel_nxt;
	end

	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		unique case (state_r)
			fpd_pkg::ST_IDLE: begin
				if (avs_write && strobe_wr) begin
					state_nxt = fpd_pkg::ST_SETUP;
					tmr_nxt = tmr_load(SETUP_CYC);
				end else if (avs_read && avs_address == `FPD_ADDR_TUNE) begin
					state_nxt = fpd_pkg::ST_FREEZE;
					tmr_nxt = tmr_load(FREEZE_CYC);
				end else if (avs_write || avs_read) begin
					state_nxt = fpd_pkg::ST_ACK;
				end
			end
			fpd_pkg::ST_SETUP: begin
				tmr_nxt = tmr_r - 8'h01;
				if (tmr_r == 8'h00) begin
					state_nxt = fpd_pkg::ST_STROBE;
					tmr_nxt = tmr_load(STROBE_CYC);
				end
			end
			fpd_pkg::ST_STROBE: begin
				tmr_nxt = tmr_r - 8'h01;
				if (tmr_r == 8'h00) begin
					state_nxt = fpd_pkg::ST_HOLD;
					tmr_nxt = tmr_load(HOLD_CYC);
				end
			end
			fpd_pkg::ST_HOLD, fpd_pkg::ST_FREEZE: begin
				tmr_nxt = tmr_r - 8'h01;
				if (tmr_r == 8'h00) begin
					state_nxt = fpd_pkg::ST_ACK;
				end
			end
			fpd_pkg::ST_ACK: state_nxt = fpd_pkg::ST_IDLE;
		endcase
	end

	// Waitrequest only drops once the strobe cycle is complete
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= fpd_pkg::ST_IDLE;
			tmr_r <= 8'h00;
			avs_waitrequest <= 1'b1;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			avs_waitrequest <= state_nxt != fpd_pkg::ST_ACK;
		end
	end

	// Data and select settle before the strobe and stay through the hold
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stb_sel_r <= '0;
			disp_data <= 8'h00;
			matrix_instr_data_select <= 1'b1;
		end else if (wr_take && strobe_wr) begin
			stb_sel_r <= stb_sel_nxt;
			if (avs_address == `FPD_ADDR_FREQ_SHIFT) begin
				disp_data <= {2'b00, avs_writedata[`FPD_FREQ_BITS-1:0]};
			end else if (avs_address == `FPD_ADDR_BAR_SHIFT) begin
				disp_data <= {6'b00_0000, avs_writedata[`FPD_BAR_BITS-1:0]};
			end else if (avs_address != `FPD_ADDR_LOAD) begin
				disp_data <= avs_writedata[7:0];
			end
			if (avs_address == `FPD_ADDR_MTX_INSTR) begin
				matrix_instr_data_select <= 1'b0;
			end else if (avs_address == `FPD_ADDR_MTX_CHAR) begin
				matrix_instr_data_select <= 1'b1;
			end
		end
	end

	// Each strobe is low only in STROBE, inside its own bus cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freq_shift_n <= 1'b1;
			bar_shift_n <= 1'b1;
			freq_load_n <= 1'b1;
			bar_load_n <= 1'b1;
			matrix_char_strobe_n <= 1'b1;
		end else begin
			freq_shift_n <= !(state_nxt == fpd_pkg::ST_STROBE && stb_sel_r[`FPD_STB_FREQ_SHIFT]);
			bar_shift_n <= !(state_nxt == fpd_pkg::ST_STROBE && stb_sel_r[`FPD_STB_BAR_SHIFT]);
			freq_load_n <= !(state_nxt == fpd_pkg::ST_STROBE && stb_sel_r[`FPD_STB_FREQ_LOAD]);
			bar_load_n <= !(state_nxt == fpd_pkg::ST_STROBE && stb_sel_r[`FPD_STB_BAR_LOAD]);
			matrix_char_strobe_n <= !(state_nxt == fpd_pkg::ST_STROBE && stb_sel_r[`FPD_STB_MTX]);
		end
	end

	// Image byte counts; a load after other than twenty bytes is flagged
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freq_cnt_r <= 5'h00;
			bar_cnt_r <= 5'h00;
			freq_short_r <= 1'b0;
			bar_short_r <= 1'b0;
		end else begin
			if (wr_take && lane0 && avs_address == `FPD_ADDR_STATUS) begin
				if (avs_writedata[`FPD_ST_FREQ_SHORT]) freq_short_r <= 1'b0;
				if (avs_writedata[`FPD_ST_BAR_SHORT]) bar_short_r <= 1'b0;
			end
			if (wr_take && stb_sel_nxt[`FPD_STB_FREQ_SHIFT]) freq_cnt_r <= sat_inc(freq_cnt_r);
			if (wr_take && stb_sel_nxt[`FPD_STB_BAR_SHIFT]) bar_cnt_r <= sat_inc(bar_cnt_r);
			// Set after clear so a coinciding event is kept
			if (wr_take && stb_sel_nxt[`FPD_STB_FREQ_LOAD]) begin
				freq_cnt_r <= 5'h00;
				if (freq_cnt_r != `FPD_IMAGE_BYTES) freq_short_r <= 1'b1;
			end
			if (wr_take && stb_sel_nxt[`FPD_STB_BAR_LOAD]) begin
				bar_cnt_r <= 5'h00;
				if (bar_cnt_r != `FPD_IMAGE_BYTES) bar_short_r <= 1'b1;
			end
		end
	end

	// Plain latches: legends, test bit, view angle, lamp, control, key row
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			legend <= '0;
			built_in_test <= 1'b0;
			view_angle <= `FPD_VIEW_RESET;
			lamp_level_r <= `FPD_LAMP_RESET;
			speaker_mute <= 1'b0;
			comparator_en <= 1'b0;
			key_sel_r <= 4'h0;
		end else if (wr_take && lane0) begin
			unique case (avs_address)
				`FPD_ADDR_LEGEND: begin
					legend <= avs_writedata[`FPD_LEGEND_BITS-1:0];
					built_in_test <= avs_writedata[`FPD_BIT_BUILT_IN_TEST];
				end
				`FPD_ADDR_VIEW: view_angle <= avs_writedata[7:0];
				`FPD_ADDR_LAMP: lamp_level_r <= avs_writedata[`FPD_LAMP_BITS-1:0];
				`FPD_ADDR_CTRL: begin
					speaker_mute <= avs_writedata[`FPD_CTRL_MUTE];
					comparator_en <= avs_writedata[`FPD_CTRL_CMP_EN];
				end
				`FPD_ADDR_KEYS: key_sel_r <= avs_writedata[3:0];
				default: key_sel_r <= key_sel_r;
			endcase
		end
	end

	// One row low at a time while scanning; invalid rows drive none
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			key_row_n <= '1;
		end else begin
			for (int i = 0; i < `FPD_KEY_ROWS; i++) begin
				key_row_n[i] <= !(key_sel_r[`FPD_KEY_SCAN_BIT] && key_sel_r[2:0] == 3'(i));
			end
		end
	end

	// Pin inputs pass two flops before any logic sees them
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			a_s1_r <= 1'b0;
			a_s2_r <= 1'b0;
			a_d_r <= 1'b0;
			b_s1_r <= 1'b0;
			b_s2_r <= 1'b0;
			b_d_r <= 1'b0;
			key_s1_r <= '1;
			key_s2_r <= '1;
		end else begin
			a_s1_r <= enc_a;
			a_s2_r <= a_s1_r;
			a_d_r <= a_s2_r;
			b_s1_r <= enc_b;
			b_s2_r <= b_s1_r;
			b_d_r <= b_s2_r;
			key_s1_r <= key_return_n;
			key_s2_r <= key_s1_r;
		end
	end

	// Steps on every phase change; a step during the freeze is lost
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tune_count_r <= 8'h00;
		end else if (state_r != fpd_pkg::ST_FREEZE && ((a_s2_r ^ a_d_r) || (b_s2_r ^ b_d_r))) begin
			tune_count_r <= (a_d_r ^ b_s2_r) ? tune_count_r + 8'h01 : tune_count_r - 8'h01;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			`FPD_ADDR_TUNE: rd_mux[7:0] = tune_count_r;
			`FPD_ADDR_KEYS: rd_mux[`FPD_KEY_COLS-1:0] = key_s2_r;
			`FPD_ADDR_IDENT: rd_mux[7:0] = IDENT_CODE;
			`FPD_ADDR_LEGEND: rd_mux[7:0] = {built_in_test, legend};
			`FPD_ADDR_VIEW: rd_mux[7:0] = view_angle;
			`FPD_ADDR_LAMP: rd_mux[`FPD_LAMP_BITS-1:0] = lamp_level_r;
			`FPD_ADDR_CTRL: rd_mux[1:0] = {comparator_en, speaker_mute};
			`FPD_ADDR_STATUS: begin
				rd_mux[`FPD_ST_FREQ_CNT +: 5] = freq_cnt_r;
				rd_mux[`FPD_ST_BAR_CNT +: 5] = bar_cnt_r;
				rd_mux[`FPD_ST_FREQ_SHORT] = freq_short_r;
				rd_mux[`FPD_ST_BAR_SHORT] = bar_short_r;
				rd_mux[`FPD_ST_KEY_DOWN] = !(&key_s2_r);
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Counter value is taken at the end of the freeze, so it is steady
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if ((rd_take && avs_address != `FPD_ADDR_TUNE) ||
				(state_r == fpd_pkg::ST_FREEZE && tmr_r == 8'h00)) begin
			avs_readdata <= rd_mux;
		end
	end

	fpd_lamp_drive #(
		.LCD_HALF_CYC(LCD_HALF_CYC),
		.PWM_STEP_CYC(`FPD_PWM_STEP_CYC)
	) u_lamp (
		.clock(clock),
		.rst_b(rst_b),
		.level(lamp_level_r),
		.lcd_drive(lcd_drive),
		.lamp_pwm(lamp_pwm)
	);
endmodule : fpd_panel_port
`default_nettype wire

// ---- fpd_port_checker.sv ----
// Concurrent checks on the front-panel port pins.
// Assumes one clock domain; bound to the port from the testbench file.
`timescale 1ns/100ps
`default_nettype none
module fpd_port_checker #(
	parameter int LCD_HALF_CYC = 8,
	parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
	input wire logic clock, // Clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [7:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Stall
	input wire logic [7:0] disp_data, // Display data bus
	input wire logic freq_shift_n, // Frequency shift strobe
	input wire logic freq_load_n, // Frequency latch strobe
	input wire logic bar_shift_n, // Bar shift strobe
	input wire logic bar_load_n, // Bar latch strobe
	input wire logic matrix_char_strobe_n, // Matrix strobe
	input wire logic matrix_instr_data_select, // Instruction or data
	input wire logic [6:0] legend, // Legend latch
	input wire logic built_in_test, // Test bit
	input wire logic [7:0] view_angle, // View angle word
	input wire logic lcd_drive // Module drive square wave
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	logic all_high;
	logic [7:0] low_cnt_r;
	logic lcd_q_r;
	logic lcd_seen_r;
	int lcd_cnt_r;
	assign all_high = &{freq_shift_n, freq_load_n, bar_shift_n, bar_load_n, matrix_char_strobe_n};
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_r <= 8'h00;
		end else begin
			low_cnt_r <= all_high ? 8'h00 : low_cnt_r + 8'h01;
		end
	end
	// Period is only known after the first edge, the phase at release is free
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lcd_q_r <= 1'b0;
			lcd_seen_r <= 1'b0;
			lcd_cnt_r <= 0;
		end else begin
			lcd_q_r <= lcd_drive;
			lcd_cnt_r <= (lcd_drive != lcd_q_r) ? 1 : lcd_cnt_r + 1;
			lcd_seen_r <= lcd_seen_r | (lcd_drive != lcd_q_r);
		end
	end
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_wait_pulse: assert property ($fell(avs_waitrequest) |-> s_answer)
		else $error("answer longer than one cycle");
	a_strobe_width: assert property ($rose(all_high) |-> low_cnt_r == 8'h1E)
		else $error("strobe width wrong");
	a_strobe_inside: assert property (!all_high |-> avs_write && !avs_read)
		else $error("strobe outside write cycle");
	a_freq_addr: assert property ($fell(freq_shift_n) |-> avs_address == 8'h00)
		else $error("frequency strobe on wrong address");
	a_bar_addr: assert property ($fell(bar_shift_n) |-> avs_address == 8'h04)
		else $error("bar strobe on wrong address");
	a_load_cause: assert property ($fell(freq_load_n) |-> avs_address == 8'h08 && avs_writedata[0])
		else $error("load strobe without load write");
	a_select_kind: assert property ($fell(matrix_char_strobe_n)
		|-> matrix_instr_data_select == (avs_address == 8'h10))
		else $error("select level wrong at matrix strobe");
	a_data_steady: assert property (!all_high |-> $stable(disp_data) && $stable(matrix_instr_data_select))
		else $error("data moved under strobe");
	a_view_write: assert property (avs_write && !avs_waitrequest && avs_address == 8'h18
		&& avs_byteenable[0] |-> view_angle == avs_writedata[7:0])
		else $error("view angle not written");
	a_legend_write: assert property (avs_write && !avs_waitrequest && avs_address == 8'h14
		&& avs_byteenable[0] |-> {built_in_test, legend} == avs_writedata[7:0])
		else $error("legend latch not written");
	a_ident_read: assert property (avs_read && !avs_waitrequest && avs_address == 8'h28
		|-> avs_readdata == {24'h00_0000, IDENT_CODE})
		else $error("identification read wrong");
	a_drive_period: assert property ((lcd_drive != lcd_q_r) && lcd_seen_r |-> lcd_cnt_r == LCD_HALF_CYC)
		else $error("drive wave period wrong");
endmodule : fpd_port_checker
`default_nettype wire

// ---- fpd_panel_model.sv ----
// Front-panel switch matrix and tuning knob as seen by the port.
// Assumes one key held at most; return lines pulled high when open.
`timescale 1ns/100ps
`default_nettype none
module fpd_panel_model (
	input wire logic [5:0] key_row_n, // Row drive from port
	input wire logic press_en, // A key is held
	input wire logic [2:0] press_row, // Row of held key
	input wire logic [2:0] press_col, // Column of held key
	input wire logic [1:0] knob_pos, // Knob position, one count a click
	output logic [7:0] key_return_n, // Return lines
	output logic enc_a, // Encoder phase A
	output logic enc_b // Encoder phase B
);
	always_comb begin
		key_return_n = 8'hFF;
		if (press_en && !key_row_n[press_row]) begin
			key_return_n[press_col] = 1'b0;
		end
	end
	// Gray phases, so each increment is one click in the up direction
	assign enc_a = knob_pos[1];
	assign enc_b = knob_pos[1] ^ knob_pos[0];
endmodule : fpd_panel_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the front-panel port over Avalon-MM.
// Assumes checker and panel model are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clock, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address, disp_data, view_angle, key_return_n;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic freq_shift_n, freq_load_n, bar_shift_n, bar_load_n, matrix_char_strobe_n;
	logic matrix_instr_data_select, built_in_test, lamp_pwm, lcd_drive;
	logic speaker_mute, comparator_en, enc_a, enc_b, press_en, sel_cap;
	logic [6:0] legend;
	logic [5:0] key_row_n;
	logic [1:0] knob_pos;
	logic [7:0] dat_cap;
	int error_cnt, compares, freq_falls, bar_falls, load_falls, hi;
	fpd_panel_port #(.LCD_HALF_CYC(8)) DUT (.clock(clock), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .disp_data(disp_data),
		.freq_shift_n(freq_shift_n), .freq_load_n(freq_load_n), .bar_shift_n(bar_shift_n),
		.bar_load_n(bar_load_n), .matrix_char_strobe_n(matrix_char_strobe_n),
		.matrix_instr_data_select(matrix_instr_data_select), .legend(legend),
		.built_in_test(built_in_test), .view_angle(view_angle), .lamp_pwm(lamp_pwm),
		.lcd_drive(lcd_drive), .speaker_mute(speaker_mute), .comparator_en(comparator_en),
		.key_row_n(key_row_n), .key_return_n(key_return_n), .enc_a(enc_a), .enc_b(enc_b));
	fpd_panel_model u_panel (.key_row_n(key_row_n), .press_en(press_en), .press_row(3'h2),
		.press_col(3'h5), .knob_pos(knob_pos), .key_return_n(key_return_n), .enc_a(enc_a),
		.enc_b(enc_b));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(negedge freq_shift_n) freq_falls++;
	always @(negedge bar_shift_n) bar_falls++;
	always @(negedge freq_load_n or negedge bar_load_n) load_falls++;
	always @(negedge matrix_char_strobe_n) begin
		sel_cap = matrix_instr_data_select;
		dat_cap = disp_data;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// Bounded wait for the answer edge
	task automatic wait_ack();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 300);
		if (n >= 300) begin
			error_cnt++;
			$display("Error bus answer missing");
			final_report();
		end
	endtask : wait_ack
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'h1);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a);
		@(posedge clock);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_rd
	initial begin
		{avs_read, avs_write, press_en} = 3'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h1;
		knob_pos = 2'h0;
		rst_b = 1'b0;
		repeat (3) @(posedge clock);
		check("reset pins", {view_angle, legend, built_in_test, speaker_mute, comparator_en,
			freq_shift_n, freq_load_n, bar_shift_n, bar_load_n, matrix_char_strobe_n,
			matrix_instr_data_select}, 32'h0080_003F);
		rst_b <= 1'b1;
		for (int i = 0; i < 20; i++) bus_wr(8'h00, 32'h0000_0020 + i);
		check("freq shifts", freq_falls, 20);
		check("freq byte", disp_data[5:0], 6'h33);
		check("early load", load_falls, 0);
		bus_rd(8'h2C);
		check("freq count", rd & 32'h0001_001F, 32'h0000_0014);
		bus_wr(8'h08, 32'h0000_0001);
		check("freq load", load_falls, 1);
		for (int d = 0; d < 10; d++) begin
			for (int i = 0; i < 20; i++) bus_wr(8'h00, d);
			bus_wr(8'h08, 32'h0000_0001);
		end
		check("digit byte", disp_data[5:0], 6'h09);
		check("image shifts", freq_falls, 220);
		check("image loads", load_falls, 11);
		for (int i = 0; i < 3; i++) bus_wr(8'h04, 32'h0000_0001 + i);
		check("bar shifts", bar_falls, 3);
		check("bar byte", disp_data[1:0], 2'h3);
		bus_wr(8'h08, 32'h0000_0002);
		check("bar load", load_falls, 12);
		bus_rd(8'h2C);
		check("bar short", rd & 32'h0003_1F1F, 32'h0002_0000);
		bus_wr(8'h2C, 32'h0002_0000);
		bus_rd(8'h2C);
		check("short clear", rd & 32'h0002_0000, 32'h0000_0000);
		bus_wr(8'h0C, 32'h0000_0038);
		check("instr byte", {sel_cap, dat_cap}, 9'h038);
		bus_wr(8'h10, 32'h0000_0041);
		check("char byte", {sel_cap, dat_cap}, 9'h141);
		for (int i = 0; i < 7; i++) begin
			bus_wr(8'h14, 32'h0000_0001 << i);
			check("legend step", legend, 32'h0000_0001 << i);
		end
		bus_wr(8'h14, 32'h0000_00A5);
		bus_rd(8'h14);
		check("legend latch", {rd[7:0], built_in_test, legend}, 16'hA5A5);
		bus_wr(8'h18, 32'h0000_003C);
		bus_wr(8'h18, 32'h0000_00FF, 4'h0);
		bus_rd(8'h18);
		check("view angle", {rd[7:0], view_angle}, 16'h3C3C);
		bus_wr(8'h30, 32'h0000_0003);
		check("mute and gain", {speaker_mute, comparator_en}, 2'h3);
		bus_rd(8'h28);
		check("ident", rd, 32'h0000_005A);
		bus_rd(8'h20);
		check("tuning", rd, 32'h0000_0000);
		repeat (3) begin
			repeat (4) @(posedge clock);
			knob_pos <= knob_pos + 2'h1;
		end
		repeat (8) @(posedge clock);
		bus_rd(8'h20);
		check("tuning steps", rd, 32'h0000_0003);
		for (int k = 0; k < 2; k++) begin
			bus_rd(k == 0 ? 8'h00 : 8'h3C);
			check("empty read", rd, 32'h0000_0000);
		end
		press_en <= 1'b1;
		bus_wr(8'h24, 32'h0000_000A);
		repeat (4) @(posedge clock);
		check("row drive", key_row_n, 6'h3B);
		bus_rd(8'h24);
		check("key return", rd[7:0], 8'hDF);
		check("single key", $countones(~rd[7:0]), 1);
		bus_rd(8'h2C);
		check("key down", rd[18], 1'b1);
		for (int lvl = 0; lvl < 8; lvl++) begin
			bus_wr(8'h1C, lvl);
			repeat (512) @(posedge clock);
			hi = 0;
			repeat (512) begin
				@(posedge clock);
				hi += (lamp_pwm === 1'b1);
			end
			check("lamp duty", hi, (lvl + 1) * 64);
		end
		final_report();
	end
endmodule : testbench
bind fpd_panel_port fpd_port_checker #(.LCD_HALF_CYC(LCD_HALF_CYC), .IDENT_CODE(IDENT_CODE))
	u_chk (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .disp_data(disp_data),
	.freq_shift_n(freq_shift_n), .freq_load_n(freq_load_n), .bar_shift_n(bar_shift_n),
	.bar_load_n(bar_load_n), .matrix_char_strobe_n(matrix_char_strobe_n),
	.matrix_instr_data_select(matrix_instr_data_select), .legend(legend),
	.built_in_test(built_in_test), .view_angle(view_angle), .lcd_drive(lcd_drive));
`default_nettype wire
